/* pwr_cfg_pkg.sv */
// Purpose: Constants and types shared by the power control configuration register block.
// Assumes: AHB-Lite register access, 32-bit data, one aligned word per register.
// Notes: Printed offsets are not all multiples of four, so each is a register index.
package pwr_cfg_pkg;
    localparam logic [7:0] slow_clock_config_idx = 8'hF0;
    localparam logic [7:0] irq_generation_enable_config_idx = 8'hF1;
    localparam logic [7:0] irq_frame_lo_idx = 8'h1B;
    localparam logic [7:0] irq_frame_hi_idx = 8'h1C;
    localparam logic [7:0] irq_status_idx = 8'h20;
    localparam logic [7:0] irq_mask_idx = 8'h21;
    localparam logic [9:0] slow_clock_config_addr = {slow_clock_config_idx, 2'b00};
    localparam logic [9:0] irq_generation_enable_config_addr =
        {irq_generation_enable_config_idx, 2'b00};
    localparam logic [9:0] irq_frame_lo_addr = {irq_frame_lo_idx, 2'b00};
    localparam logic [9:0] irq_frame_hi_addr = {irq_frame_hi_idx, 2'b00};
    localparam logic [9:0] irq_status_addr = {irq_status_idx, 2'b00};
    localparam logic [9:0] irq_mask_addr = {irq_mask_idx, 2'b00};
    localparam int slow_clock_absent_bit = 0;
    localparam int key_wake_logic_off_bit = 1;
    localparam int irq_gen_enable_bit = 0;
    localparam logic [7:0] slow_clock_config_rst = 8'h00;
    localparam logic [7:0] irq_generation_enable_config_rst = 8'h00;
    localparam logic [7:0] slow_clock_config_wmask = 8'h03;
    localparam logic [7:0] irq_generation_enable_config_wmask = 8'h01;
    localparam logic [15:0] irq_frame_rst = 16'h0000;
    localparam logic [1:0] evt_rst = 2'b00;
    localparam int evt_cfg_change = 0;
    localparam int evt_frames_blocked = 1;
    localparam logic [1:0] htrans_nonseq = 2'b10;
    localparam logic [2:0] hsize_word = 3'b010;

    typedef struct packed {
        logic sel;
        logic write;
        logic [9:0] addr;
    } ahb_req_t;

    typedef struct packed {
        logic slow_clock_absent;
        logic key_wake_logic_off;
        logic irq_gen_enable;
    } cfg_t;
endpackage

/* pin_sync.sv */
// Purpose: Three-stage synchroniser that accepts a change once stages two and three agree.
// Assumes: Input is asynchronous to clk.
// Notes: The first stage is read only by the second.
`timescale 1ns/10ps
module pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule

/* power_ctrl_config_regs.sv */
// Purpose: Power control configuration registers on AHB-Lite with frame gating and clock gate.
// Assumes: One clock; standby and main resets arrive as synchronous active-high inputs.
// Notes: Writes take no wait state, reads take one; unmapped addresses read zero, OKAY.
`timescale 1ns/10ps
module power_ctrl_config_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic main_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic slow_clock_input_pin,
    input wire logic [15:0] irq_frame_request,
    output logic [15:0] irq_frame_drive_low,
    output logic key_wake_clk_en,
    output logic key_wake_slow_tick,
    output pwr_cfg_pkg::cfg_t cfg,
    output logic irq
);
    import pwr_cfg_pkg::*;

    // ---------------------------------------------
    // Bus address phase capture
    // ---------------------------------------------
    ahb_req_t req;
    logic [7:0] slow_clock_config;
    logic [7:0] irq_generation_enable_config;
    logic [15:0] irq_generating_registers;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic slow_pin;
    logic slow_pin_d;
    logic wr;
    logic [1:0] evt;
    logic [31:0] next_rdata;
    logic rd_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            req <= '0;
        end else if (hready) begin
            req.sel <= hsel && (htrans == htrans_nonseq) && (hsize == hsize_word);
            req.write <= hwrite;
            req.addr <= haddr[9:0];
        end
    end

    assign wr = req.sel && req.write;
    // A read stalls one cycle so that its data come from a flip-flop and see a write just landed.
    assign hreadyout = !(req.sel && !req.write && !rd_ready);

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ready <= 1'b0;
        end else begin
            rd_ready <= req.sel && !req.write && !rd_ready;
        end
    end
    assign hresp = 1'b0;

    // ---------------------------------------------
    // Configuration registers
    // ---------------------------------------------
    // The slow-clock register survives main resets and clears only on standby reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            slow_clock_config <= slow_clock_config_rst;
        end else if (wr && req.addr == slow_clock_config_addr) begin
            slow_clock_config <= hwdata[7:0] & slow_clock_config_wmask;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || main_rst) begin
            irq_generation_enable_config <= irq_generation_enable_config_rst;
        end else if (wr && req.addr == irq_generation_enable_config_addr) begin
            irq_generation_enable_config <= hwdata[7:0] & irq_generation_enable_config_wmask;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || main_rst) begin
            irq_generating_registers <= irq_frame_rst;
        end else if (wr && req.addr == irq_frame_lo_addr) begin
            irq_generating_registers[7:0] <= hwdata[7:0];
        end else if (wr && req.addr == irq_frame_hi_addr) begin
            irq_generating_registers[15:8] <= hwdata[7:0];
        end
    end

    assign cfg.slow_clock_absent = slow_clock_config[slow_clock_absent_bit];
    assign cfg.key_wake_logic_off = slow_clock_config[key_wake_logic_off_bit];
    assign cfg.irq_gen_enable = irq_generation_enable_config[irq_gen_enable_bit];

    // ---------------------------------------------
    // Slow clock and key-wake gating
    // ---------------------------------------------
    pin_sync u_slow_sync (
        .clk(clk),
        .rst(rst),
        .din(slow_clock_input_pin),
        .dout(slow_pin)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            slow_pin_d <= 1'b0;
            key_wake_slow_tick <= 1'b0;
        end else begin
            slow_pin_d <= slow_pin;
            // A grounded pin or disabled logic gives no ticks at all.
            key_wake_slow_tick <= slow_pin && !slow_pin_d && !cfg.slow_clock_absent
                && !cfg.key_wake_logic_off;
        end
    end

    assign key_wake_clk_en = !cfg.key_wake_logic_off && !cfg.slow_clock_absent;

    // ---------------------------------------------
    // Serial IRQ frame gating
    // ---------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || main_rst) begin
            irq_frame_drive_low <= irq_frame_rst;
        end else if (cfg.irq_gen_enable) begin
            irq_frame_drive_low <= irq_frame_request & irq_generating_registers;
        end else begin
            irq_frame_drive_low <= irq_frame_rst;
        end
    end

    // ---------------------------------------------
    // Interrupt status and mask
    // ---------------------------------------------
    assign evt[evt_cfg_change] = wr && (req.addr == slow_clock_config_addr
        || req.addr == irq_generation_enable_config_addr);
    assign evt[evt_frames_blocked] = !cfg.irq_gen_enable
        && |(irq_frame_request & irq_generating_registers);

    // A new event in the clearing cycle keeps its bit set.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status <= evt_rst;
        end else if (wr && req.addr == irq_status_addr) begin
            irq_status <= (irq_status & ~hwdata[1:0]) | evt;
        end else begin
            irq_status <= irq_status | evt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask <= evt_rst;
        end else if (wr && req.addr == irq_mask_addr) begin
            irq_mask <= hwdata[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ---------------------------------------------
    // Read data
    // ---------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (req.addr)
            slow_clock_config_addr: next_rdata = {24'h00_0000, slow_clock_config};
            irq_generation_enable_config_addr:
                next_rdata = {24'h00_0000, irq_generation_enable_config};
            irq_frame_lo_addr: next_rdata = {24'h00_0000, irq_generating_registers[7:0]};
            irq_frame_hi_addr: next_rdata = {24'h00_0000, irq_generating_registers[15:8]};
            irq_status_addr: next_rdata = {30'h0000_0000, irq_status};
            irq_mask_addr: next_rdata = {30'h0000_0000, irq_mask};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (req.sel && !req.write && !rd_ready) begin
            hrdata <= next_rdata;
        end
    end

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    AST_GATE_OFF: assert property (@(posedge clk) disable iff (rst)
        !cfg.irq_gen_enable |=> irq_frame_drive_low == 16'h0000)
        else $error("Frames driven while generation disabled.");
    AST_GATE_ON: assert property (@(posedge clk) disable iff (rst || main_rst)
        cfg.irq_gen_enable && !main_rst |=> irq_frame_drive_low ==
        ($past(irq_frame_request) & $past(irq_generating_registers)))
        else $error("Frame drive does not follow requests.");
    AST_CLK_GATE: assert property (@(posedge clk) disable iff (rst)
        cfg.key_wake_logic_off |-> !key_wake_clk_en)
        else $error("Key-wake clock runs while logic is off.");
    AST_TICK_OFF: assert property (@(posedge clk) disable iff (rst)
        $past(cfg.key_wake_logic_off) |-> !key_wake_slow_tick)
        else $error("Key-wake tick while logic is off.");
    AST_ABSENT: assert property (@(posedge clk) disable iff (rst)
        $past(cfg.slow_clock_absent) |-> !key_wake_slow_tick)
        else $error("Slow tick with clock absent.");
    AST_MAIN_RST: assert property (@(posedge clk) disable iff (rst)
        main_rst |=> !cfg.irq_gen_enable && irq_generating_registers == 16'h0000)
        else $error("Main reset did not clear enable.");
    AST_KEEP_SLOW: assert property (@(posedge clk) disable iff (rst)
        main_rst && !wr |=> $stable(slow_clock_config))
        else $error("Main reset disturbed slow-clock register.");
    AST_FRAME_WR: assert property (@(posedge clk) disable iff (rst || main_rst)
        wr && req.addr == irq_frame_lo_addr |=>
        irq_generating_registers[7:0] == $past(hwdata[7:0]))
        else $error("Frame register write lost.");
    AST_IRQ: assert property (@(posedge clk) disable iff (rst)
        evt[evt_cfg_change] |=> irq_status[evt_cfg_change])
        else $error("Configuration event did not set its status bit.");
    COV_ENABLE: cover property (@(posedge clk) cfg.irq_gen_enable ##1 |irq_frame_drive_low);
    COV_KEY_OFF: cover property (@(posedge clk) cfg.key_wake_logic_off);
    COV_TICK: cover property (@(posedge clk) key_wake_slow_tick);
    COV_IRQ: cover property (@(posedge clk) irq);
endmodule

/* slow_clock_source.sv */
// Purpose: Board-side model of the slow clock that may feed the slow clock pin.
// Assumes: A 32kHz source whose half period is a parameter.
// Notes: With no source fitted the pin is grounded.
`timescale 1ns/10ps
module slow_clock_source #(
    parameter int half_ns = 15625
) (
    input wire logic connected,
    output logic pin
);
    initial pin = 1'b0;
    always begin
        #half_ns;
        pin = connected ? ~pin : 1'b0;
    end
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the power control configuration registers.
// Assumes: AHB-Lite slave whose reads may stall; hready is fed back from hreadyout.
// Notes: Reads are checked by a monitor against a queue of expected values.
`timescale 1ns/10ps
module testbench;
    import pwr_cfg_pkg::*;
    logic clk, rst, main_rst, hsel, hwrite, hready, hreadyout, hresp, irq, pin, clk_en, tick;
    logic [31:0] haddr, hwdata, hrdata, r, errors, samples_checked, ticks, cycles;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] req, drv, fr;
    logic rd_phase;
    cfg_t cfg;
    logic [31:0] exp_q[$];
    integer seed, i;
    assign hready = hreadyout;
    slow_clock_source src (.connected(1'b1), .pin(pin));
    power_ctrl_config_regs dut (.clk(clk), .rst(rst), .main_rst(main_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .slow_clock_input_pin(pin), .irq_frame_request(req), .irq_frame_drive_low(drv),
        .key_wake_clk_en(clk_en), .key_wake_slow_tick(tick), .cfg(cfg), .irq(irq));
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked = samples_checked + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out;
        if (errors == 0 && samples_checked != 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    task automatic ahb(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        hsel <= 1'b1;
        haddr <= {22'h000000, a};
        htrans <= htrans_nonseq;
        hwrite <= wr;
        hsize <= hsize_word;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        if (!wr) exp_q.push_back(e);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (tick === 1'b1) ticks = ticks + 1;
        if (cycles == 32'd60000) begin
            errors = errors + 1;
            close_out();
        end
        if (hreadyout === 1'b1) begin
            if (rd_phase) begin
                if (exp_q.size() == 0) check("read_queue", 32'h1, 32'h0);
                else check("hrdata", hrdata, exp_q.pop_front());
                check("hresp", {31'h0, hresp}, 32'h0);
            end
            rd_phase = hsel && htrans == htrans_nonseq && !hwrite;
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {errors, samples_checked, ticks, cycles, rd_phase} = '0;
        seed = 63957;
        {rst, main_rst, hsel, hwrite, haddr, htrans, hsize, hwdata, req} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check("cfg", {29'h0, cfg}, 32'h0);
        check("clk_en", {31'h0, clk_en}, 32'h1);
        @(posedge clk);
        ahb(0, slow_clock_config_addr, 0, 0);
        ahb(0, irq_generation_enable_config_addr, 0, 0);
        ahb(0, 10'h100, 0, 0);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            ahb(1, slow_clock_config_addr, (r & 32'hFFFFFFFC) | i, 0);
            ahb(0, slow_clock_config_addr, 0, i);
            #1 check("absent", {31'h0, cfg.slow_clock_absent}, i & 1);
            check("key_off", {31'h0, cfg.key_wake_logic_off}, i >> 1);
            check("clk_en", {31'h0, clk_en}, {31'h0, i == 0});
            @(posedge clk);
        end
        ahb(1, slow_clock_config_addr, 0, 0);
        ticks = 0;
        repeat (9000) @(posedge clk);
        check("ticks_on", {31'h0, ticks != 0}, 32'h1);
        ahb(1, slow_clock_config_addr, 32'h2, 0);
        ticks = 0;
        repeat (9000) @(posedge clk);
        check("ticks_off", ticks, 32'h0);
        fr = $random(seed);
        ahb(1, irq_frame_lo_addr, {24'h0, fr[7:0]}, 0);
        ahb(1, irq_frame_hi_addr, {24'h0, fr[15:8]}, 0);
        ahb(0, irq_frame_lo_addr, 0, {24'h0, fr[7:0]});
        ahb(0, irq_frame_hi_addr, 0, {24'h0, fr[15:8]});
        req <= $random(seed);
        repeat (3) @(posedge clk);
        #1 check("drive_off", {16'h0, drv}, 32'h0);
        @(posedge clk);
        ahb(1, irq_generation_enable_config_addr, 32'hFFFFFFFF, 0);
        ahb(0, irq_generation_enable_config_addr, 0, 1);
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            req <= $random(seed);
            @(posedge clk);
            #1 check("drive_on", {16'h0, drv}, {16'h0, req & fr});
        end
        @(posedge clk);
        req <= 16'h0000;
        ahb(1, irq_mask_addr, 32'h1, 0);
        #1 check("irq_set", {31'h0, irq}, 32'h1);
        @(posedge clk);
        ahb(1, irq_status_addr, 32'h3, 0);
        #1 check("irq_clr", {31'h0, irq}, 32'h0);
        @(posedge clk);
        ahb(0, irq_status_addr, 0, 0);
        ahb(1, slow_clock_config_addr, 32'h1, 0);
        main_rst <= 1'b1;
        @(posedge clk);
        main_rst <= 1'b0;
        @(posedge clk);
        ahb(0, irq_generation_enable_config_addr, 0, 0);
        ahb(0, slow_clock_config_addr, 0, 1);
        ahb(0, irq_frame_lo_addr, 0, 0);
        #1 check("drive_rst", {16'h0, drv}, 32'h0);
        close_out();
    end
endmodule
